// ### hw/home_return_params.svh
// Offsets, field positions, reset values and timing counts for the home-return sequencer.
`ifndef HOME_RETURN_PARAMS_SVH
`define HOME_RETURN_PARAMS_SVH
`define HR_ADDR_W 4
`define HR_OFF_RET_TYPE 4'h0
`define HR_OFF_SHARED 4'h1
`define HR_OFF_DEC_LVL 4'h2
`define HR_OFF_DIR 4'h3
`define HR_OFF_CMD 4'h4
`define HR_OFF_STATUS 4'h5
`define HR_OFF_BUSY 4'h6
`define HR_CMD_POS_BIT 0
`define HR_CMD_NEG_BIT 1
`define HR_CMD_MODE_BIT 2
`define HR_RST_CFG 8'h00
`define HR_SHARED_AXES 4
`define HR_STOP_TIME_US 10
`define HR_CLK_MHZ 25
`define HR_STOP_CYCLES ((`HR_STOP_TIME_US * `HR_CLK_MHZ) < 1 ? 1 : (`HR_STOP_TIME_US * `HR_CLK_MHZ))
`endif

// ### hw/home_return_pkg.sv
// Types shared by the home-return sequencer files.
package home_return_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_RAPID = 3'b001,
      ST_SLOW = 3'b010,
      ST_ZERO = 3'b011,
      ST_STOP_REV = 3'b100,
      ST_SECOND = 3'b101,
      ST_SECOND_OFF = 3'b110
   } hr_state_t;
   typedef enum logic [1:0] {
      SPD_STOP = 2'b00,
      SPD_LOW = 2'b01,
      SPD_RAPID = 2'b10
   } hr_speed_t;
endpackage

// ### hw/axis_home_fsm.sv
// One axis home-return state machine.
`timescale 1ns/1ps
`default_nettype none
`include "home_return_params.svh"
module axis_home_fsm
   import home_return_pkg::*;
#(
   parameter int STOP_CYCLES = `HR_STOP_CYCLES,
   parameter bit SHARED_OK = 1'b1
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic start,
   input wire logic start_neg,
   input wire logic abort,
   input wire logic ret_type_c,
   input wire logic shared_sw,
   input wire logic dec_level,
   input wire logic dir_neg,
   input wire logic decel_in,
   input wire logic zero_in,
   output logic busy_r,
   output logic done_r,
   output hr_speed_t speed_r,
   output logic dir_r
);
   hr_state_t state_r, state_nxt;
   logic busy_nxt, done_nxt, dir_nxt;
   hr_speed_t speed_nxt;
   logic dec_act, dec_prev_r, zero_prev_r, shared_eff;
   logic [15:0] cnt_r, cnt_nxt;
   // Both levels selected by the level bit, applied combinationally throughout the return.
   assign dec_act = decel_in ^ ~dec_level;
   assign shared_eff = shared_sw & SHARED_OK;
   always_comb begin
      state_nxt = state_r;
      busy_nxt = busy_r;
      done_nxt = done_r;
      speed_nxt = speed_r;
      dir_nxt = dir_r;
      cnt_nxt = cnt_r;
      if (abort) begin
         // A stop count cut short here must not shorten the next type C stop.
         state_nxt = ST_IDLE;
         busy_nxt = 1'b0;
         speed_nxt = SPD_STOP;
         cnt_nxt = 16'h0000;
      end else begin
         case (state_r)
            ST_IDLE: begin
               if (start) begin
                  // Key direction is ignored; the configured direction wins.
                  state_nxt = ST_RAPID;
                  busy_nxt = 1'b1;
                  done_nxt = 1'b0;
                  speed_nxt = SPD_RAPID;
                  dir_nxt = dir_neg;
                  cnt_nxt = 16'h0000;
               end
            end
            ST_RAPID: begin
               if (dec_act && !dec_prev_r) begin
                  if (ret_type_c) begin
                     state_nxt = ST_STOP_REV;
                  end else begin
                     state_nxt = ST_SLOW;
                     speed_nxt = SPD_LOW;
                  end
               end
            end
            ST_SLOW: begin
               if (!dec_act) begin
                  state_nxt = ST_ZERO;
               end
            end
            ST_ZERO: begin
               if (shared_eff ? (dec_act && !dec_prev_r) : (zero_in != zero_prev_r)) begin
                  state_nxt = ST_IDLE;
                  speed_nxt = SPD_STOP;
                  busy_nxt = 1'b0;
                  done_nxt = 1'b1;
               end
            end
            ST_STOP_REV: begin
               if (cnt_r != 16'h0000) begin
                  cnt_nxt = cnt_r - 16'h0001;
                  speed_nxt = SPD_STOP;
               end else if (!dec_act && speed_r == SPD_RAPID) begin
                  speed_nxt = SPD_STOP;
                  cnt_nxt = 16'(STOP_CYCLES);
               end else if (speed_r == SPD_STOP) begin
                  dir_nxt = ~dir_r;
                  speed_nxt = SPD_LOW;
                  state_nxt = ST_SECOND;
               end
            end
            ST_SECOND: begin
               if (dec_act) begin
                  state_nxt = shared_eff ? ST_SECOND_OFF : ST_SLOW;
               end
            end
            ST_SECOND_OFF: begin
               if (!dec_act) begin
                  state_nxt = ST_IDLE;
                  speed_nxt = SPD_STOP;
                  busy_nxt = 1'b0;
                  done_nxt = 1'b1;
               end
            end
            default: begin
               state_nxt = ST_IDLE;
            end
         endcase
      end
   end
   always_ff @(posedge clk) begin
      if (!rstn) begin
         state_r <= ST_IDLE;
         busy_r <= 1'b0;
         done_r <= 1'b0;
         speed_r <= SPD_STOP;
         dir_r <= 1'b0;
         cnt_r <= 16'h0000;
         dec_prev_r <= 1'b0;
         zero_prev_r <= 1'b0;
      end else if (ce) begin
         state_r <= state_nxt;
         busy_r <= busy_nxt;
         done_r <= done_nxt;
         speed_r <= speed_nxt;
         dir_r <= dir_nxt;
         cnt_r <= cnt_nxt;
         dec_prev_r <= dec_act;
         zero_prev_r <= zero_in;
      end
   end
   a_done_stop: assert property (@(posedge clk) disable iff (!rstn)
      $rose(done_r) |-> speed_r == SPD_STOP && !busy_r)
      else $error("done set while moving");
   a_start_rapid: assert property (@(posedge clk) disable iff (!rstn)
      (ce && state_r == ST_IDLE && start && !abort) |=> speed_r == SPD_RAPID && dir_r == $past(dir_neg) && !done_r)
      else $error("start did not launch rapid");
   a_abort_stop: assert property (@(posedge clk) disable iff (!rstn)
      (ce && abort) |=> !busy_r && speed_r == SPD_STOP && cnt_r == 16'h0000)
      else $error("abort left the axis moving");
   a_b_decel_low: assert property (@(posedge clk) disable iff (!rstn)
      (ce && !abort && state_r == ST_RAPID && !ret_type_c && dec_act && !dec_prev_r) |=> speed_r == SPD_LOW)
      else $error("type B did not slow on decel");
   a_c_pass_rapid: assert property (@(posedge clk) disable iff (!rstn)
      (ce && !abort && state_r == ST_RAPID && ret_type_c && dec_act && !dec_prev_r) |=> speed_r == SPD_RAPID)
      else $error("type C left rapid early");
   a_zero_edge: assert property (@(posedge clk) disable iff (!rstn)
      (ce && !abort && state_r == ST_ZERO && !shared_eff && zero_in != zero_prev_r) |=> done_r)
      else $error("zero edge missed");
   a_shared_second: assert property (@(posedge clk) disable iff (!rstn)
      (ce && !abort && state_r == ST_ZERO && shared_eff && dec_act && !dec_prev_r) |=> done_r && speed_r == SPD_STOP)
      else $error("shared second activation missed");
   a_c_shared_stop: assert property (@(posedge clk) disable iff (!rstn)
      (ce && !abort && state_r == ST_SECOND_OFF && !dec_act) |=> done_r)
      else $error("type C shared stop missed");
   a_done_hold: assert property (@(posedge clk) disable iff (!rstn)
      (done_r && !(ce && start && state_r == ST_IDLE)) |=> done_r)
      else $error("done dropped without restart");
   a_reverse_dir: assert property (@(posedge clk) disable iff (!rstn)
      (ce && !abort && state_r == ST_STOP_REV && cnt_r == 16'h0000 && speed_r == SPD_STOP) |=> dir_r != $past(dir_r))
      else $error("type C did not reverse");
endmodule
`default_nettype wire

// ### hw/axis_home_return_sequencer.sv
// Five-axis home-return sequencer top with its register port.
// Summary of operation
// - All settings clear: type B, separate, active low.
// - Jog key in home mode starts rapid travel.
// - Type B separate: decel active drops to low.
// - Decel release, then zero edge stops, sets done.
// - Type B shared switch, active-low proximity input.
// - Shared first activation drops to low speed.
// - Shared first release starts zero watching.
// - Shared second activation stops, sets done.
// - Type C setting selects type C separate.
// - Type C passes switch, stops, reverses, slow.
// - Type C separate: second pass then zero edge.
// - Type C with shared proximity switch.
// - Type C shared: second release stops immediately.
// - Shared switch only on first four axes.
// - Direction bit one means negative travel.
// - Level bit one makes decel active high.
`timescale 1ns/1ps
`default_nettype none
`include "home_return_params.svh"
module axis_home_return_sequencer
   import home_return_pkg::*;
#(
   parameter int AXES = 5,
   parameter int STOP_CYCLES = `HR_STOP_CYCLES
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic [`HR_ADDR_W-1:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata_r,
   input wire logic [AXES-1:0] decel_in,
   input wire logic [AXES-1:0] zero_pulse_input,
   output logic [AXES-1:0] home_done,
   output logic [AXES-1:0] axis_busy,
   output logic [AXES-1:0] axis_dir,
   output logic [2*AXES-1:0] axis_speed
);
   logic [7:0] type_r, type_nxt, shared_r, shared_nxt, lvl_r, lvl_nxt, dir_r, dir_nxt, mode_r, mode_nxt;
   logic [7:0] rdata_nxt, start_r, start_nxt;
   logic [AXES-1:0] busy_w, done_w;
   ///////////////////////////////////////////////////////////////////////////
   always_comb begin
      type_nxt = type_r;
      shared_nxt = shared_r;
      lvl_nxt = lvl_r;
      dir_nxt = dir_r;
      mode_nxt = mode_r;
      start_nxt = 8'h00;
      rdata_nxt = 8'h00;
      if (wr) begin
         if (addr == `HR_OFF_RET_TYPE) begin
            type_nxt = wdata;
         end else if (addr == `HR_OFF_SHARED) begin
            shared_nxt = wdata & 8'h0F;
         end else if (addr == `HR_OFF_DEC_LVL) begin
            lvl_nxt = wdata;
         end else if (addr == `HR_OFF_DIR) begin
            dir_nxt = wdata;
         end else if (addr == `HR_OFF_CMD) begin
            mode_nxt = {7'h00, wdata[`HR_CMD_MODE_BIT]};
            // Either jog key launches the selected axis, only in home mode.
            if (wdata[`HR_CMD_MODE_BIT] && (wdata[`HR_CMD_POS_BIT] || wdata[`HR_CMD_NEG_BIT])) begin
               start_nxt = {5'h00, wdata[7:5]} < 8'(AXES) ? (8'h01 << wdata[7:5]) : 8'h00;
            end
         end
      end
      if (rd) begin
         if (addr == `HR_OFF_RET_TYPE) begin
            rdata_nxt = type_r;
         end else if (addr == `HR_OFF_SHARED) begin
            rdata_nxt = shared_r;
         end else if (addr == `HR_OFF_DEC_LVL) begin
            rdata_nxt = lvl_r;
         end else if (addr == `HR_OFF_DIR) begin
            rdata_nxt = dir_r;
         end else if (addr == `HR_OFF_CMD) begin
            rdata_nxt = mode_r;
         end else if (addr == `HR_OFF_STATUS) begin
            rdata_nxt = 8'(done_w);
         end else if (addr == `HR_OFF_BUSY) begin
            rdata_nxt = 8'(busy_w);
         end else begin
            rdata_nxt = 8'h00;
         end
      end
   end
   always_ff @(posedge clk) begin
      if (!rstn) begin
         type_r <= `HR_RST_CFG;
         shared_r <= `HR_RST_CFG;
         lvl_r <= `HR_RST_CFG;
         dir_r <= `HR_RST_CFG;
         mode_r <= `HR_RST_CFG;
         start_r <= 8'h00;
         rdata_r <= 8'h00;
      end else if (ce) begin
         type_r <= type_nxt;
         shared_r <= shared_nxt;
         lvl_r <= lvl_nxt;
         dir_r <= dir_nxt;
         mode_r <= mode_nxt;
         start_r <= start_nxt;
         rdata_r <= rdata_nxt;
      end
   end
   ///////////////////////////////////////////////////////////////////////////
   // Leaving home mode aborts any running return; done flags stay.
   genvar g;
   generate
      for (g = 0; g < AXES; g++) begin : g_axis
         hr_speed_t spd;
         axis_home_fsm #(
            .STOP_CYCLES(STOP_CYCLES),
            .SHARED_OK(g < `HR_SHARED_AXES)
         ) u_fsm (
            .clk(clk),
            .rstn(rstn),
            .ce(ce),
            .start(start_r[g]),
            .start_neg(1'b0),
            .abort(~mode_r[0]),
            .ret_type_c(type_r[g]),
            .shared_sw(shared_r[g]),
            .dec_level(lvl_r[g]),
            .dir_neg(dir_r[g]),
            .decel_in(decel_in[g]),
            .zero_in(zero_pulse_input[g]),
            .busy_r(busy_w[g]),
            .done_r(done_w[g]),
            .speed_r(spd),
            .dir_r(axis_dir[g])
         );
         assign axis_speed[2*g+1:2*g] = spd;
      end
   endgenerate
   assign home_done = done_w;
   assign axis_busy = busy_w;
   a_status_read: assert property (@(posedge clk) disable iff (!rstn)
      (ce && rd && addr == `HR_OFF_STATUS) |=> rdata_r == 8'($past(done_w)))
      else $error("status read wrong");
   a_shared_mask: assert property (@(posedge clk) disable iff (!rstn) shared_r[7:4] == 4'h0)
      else $error("shared bit beyond fourth axis");
endmodule
`default_nettype wire

// ### bench/switch_model.sv
// Behavioural deceleration dogs and encoder index for every axis, moved by the sequencer outputs.
`timescale 1ns/1ps
`default_nettype none
module switch_model
   import home_return_pkg::*;
#(
   parameter int AXES = 5
) (
   input wire logic clk,
   input wire logic [AXES-1:0] level,
   input wire logic [AXES-1:0] busy,
   input wire logic [AXES-1:0] dir,
   input wire logic [2*AXES-1:0] speed,
   output logic [AXES-1:0] decel,
   output logic [AXES-1:0] zero
);
   int pos [AXES] = '{default: 0};
   logic [AXES-1:0] busy_q = '0;
   ////////////////////////////////////////////////////////////////////////////////
   // Every new return starts from the same spot, so stop positions can be predicted.
   always @(posedge clk) begin
      busy_q <= busy;
      for (int a = 0; a < AXES; a++) begin
         if (busy[a] && !busy_q[a]) begin
            pos[a] <= 0;
         end else begin
            pos[a] <= pos[a] + (dir[a] ? -1 : 1) *
               (speed[2*a+:2] == SPD_RAPID ? 4 : (speed[2*a+:2] == SPD_LOW ? 1 : 0));
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   // Two dogs on each side of the start; the second one acts as the zero tongue of a shared switch.
   always_comb begin
      for (int a = 0; a < AXES; a++) begin
         int m;
         m = pos[a] < 0 ? -pos[a] : pos[a];
         decel[a] = level[a] ~^ ((m >= 40 && m <= 60) || (m >= 100 && m <= 110));
         zero[a] = m[3];
      end
   end
endmodule
`default_nettype wire

// ### bench/tb_top.sv
// Self-checking bench for the five-axis home-return sequencer.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import home_return_pkg::*;
   localparam int AXES = 5;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic ce = 1'b1;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic rd_q = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rdata_r;
   logic [7:0] lfsr = 8'h50;
   logic [AXES-1:0] decel_in, zero_in, home_done, busy, dir;
   logic [AXES-1:0] lvl = '0;
   logic [AXES-1:0] done_q = '0;
   logic [AXES-1:0] done_acc = '0;
   logic [2*AXES-1:0] speed;
   logic [7:0] rd_exp[$];
   logic [7:0] done_exp[$];
   int mismatches = 0;
   int checks = 0;
   int cycles = 0;
   ////////////////////////////////////////////////////////////////////////////////
   axis_home_return_sequencer #(.AXES(AXES), .STOP_CYCLES(4)) u_dut (
      .clk(clk), .rstn(rstn), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata_r(rdata_r), .decel_in(decel_in), .zero_pulse_input(zero_in), .home_done(home_done),
      .axis_busy(busy), .axis_dir(dir), .axis_speed(speed));
   switch_model #(.AXES(AXES)) u_model (
      .clk(clk), .level(lvl), .busy(busy), .dir(dir), .speed(speed), .decel(decel_in), .zero(zero_in));
   initial begin
      forever #20 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] lfsr_next(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // A gap cycle follows every strobe so no strobe is assigned twice in one time step.
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
      addr <= a;
      rd <= 1'b1;
      rd_exp.push_back(exp);
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
   endtask
   // One complete return of one axis; lo and hi bound its distance from the start point when it stops.
   task automatic run(input int ax, input bit tc, input bit sh, input bit lv, input int lo, input int hi);
      logic [7:0] m;
      logic dn;
      int i;
      m = 8'h01 << ax;
      lfsr = lfsr_next(lfsr);
      dn = lfsr[0];
      lvl <= lv ? m[AXES-1:0] : '0;
      wr_reg(4'h0, tc ? m : 8'h00);
      wr_reg(4'h1, sh ? m : 8'h00);
      wr_reg(4'h2, lv ? m : 8'h00);
      wr_reg(4'h3, dn ? m : 8'h00);
      done_exp.push_back({3'b000, done_acc | m[AXES-1:0]});
      wr_reg(4'h4, 8'h04 | (dn ? 8'h02 : 8'h01) | 8'(ax << 5));
      #1;
      check("speed", {6'h00, speed[2*ax+:2]}, {6'h00, SPD_RAPID});
      check("dir", {7'h00, dir[ax]}, {7'h00, dn});
      for (i = 0; i < 3000 && home_done[ax] !== 1'b1; i++) begin
         @(posedge clk);
      end
      #1;
      i = u_model.pos[ax] < 0 ? -u_model.pos[ax] : u_model.pos[ax];
      check("stop_window", {7'h00, i >= lo && i <= hi}, 8'h01);
      check("idle", {3'b000, busy[ax], 2'b00, speed[2*ax+:2]}, 8'h00);
      done_acc[ax] = 1'b1;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Scoreboard: the oldest note is compared whenever read data or a new completion appears.
   always @(posedge clk) begin
      rd_q <= rd;
      done_q <= home_done;
      if (rd_q) begin
         check("rdata", rdata_r, rd_exp.size() ? rd_exp.pop_front() : 8'hEE);
      end
      if ((home_done & ~done_q) != '0) begin
         check("done", {3'b000, home_done}, done_exp.size() ? done_exp.pop_front() : 8'hEE);
      end
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         mismatches++;
         complete_run();
      end
   end
   initial begin
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      for (int a = 0; a < 8; a++) begin
         rd_reg(4'(a), 8'h00);
      end
      wr_reg(4'h0, 8'h1F);
      rd_reg(4'h0, 8'h1F);
      wr_reg(4'h1, 8'hFF);
      rd_reg(4'h1, 8'h0F);
      wr_reg(4'h9, 8'h5A);
      rd_reg(4'h9, 8'h00);
      // A write made while the clock enable is low must not land.
      ce <= 1'b0;
      wr_reg(4'h3, 8'h1F);
      ce <= 1'b1;
      rd_reg(4'h3, 8'h00);
      // Leaving home mode stops a running return without setting done.
      wr_reg(4'h4, 8'h05);
      rd_reg(4'h6, 8'h01);
      wr_reg(4'h4, 8'h00);
      rd_reg(4'h6, 8'h00);
      rd_reg(4'h5, 8'h00);
      run(0, 1'b0, 1'b0, 1'b0, 64, 72);
      run(1, 1'b0, 1'b1, 1'b0, 100, 108);
      run(2, 1'b1, 1'b0, 1'b0, 24, 31);
      run(3, 1'b1, 1'b1, 1'b0, 32, 39);
      run(4, 1'b0, 1'b0, 1'b1, 64, 72);
      run(4, 1'b0, 1'b1, 1'b0, 64, 72);
      rd_reg(4'h5, 8'h1F);
      rd_reg(4'h6, 8'h00);
      repeat (4) @(posedge clk);
      check("pending", 8'(rd_exp.size() + done_exp.size()), 8'h00);
      complete_run();
   end
endmodule
`default_nettype wire
